// ### rtl/cdr_lock_detector.sv
// Frequency lock detector and acquisition control for the CDR receiver
//
// Operation
// [RULE1] Error above 1000 ppm raises loss of lock and starts a new acquisition.
// [RULE2] Each acquisition first sets the oscillator to the bottom of its range.
// [RULE3] The search only steps the oscillator upward, in large steps at first.
// [RULE4] Steps shrink near the target and lock is declared within 250 ppm.
// [RULE5] Once locked the frequency loop is switched off and the phase loops run.
// [RULE6] Normal mode locks to the data rate with no reference clock.
// [RULE7] Reference mode is chosen by setting the reference lock select bit.
// [RULE8] Software sets range and divide ratio so the reference matches the data.
// [RULE9] Reference mode compares the oscillator with the divided reference.
// [RULE10] In reference mode a later error above 1000 ppm reacquires on the reference.
// [RULE11] Any loss-of-lock event sets a sticky flag that survives relock.
// [RULE12] Writing one then zero to the sticky clear bit clears the sticky flag.
// [RULE13] With pin sticky select set the loss-of-lock pin shows the sticky flag.
// [RULE14] Pin sticky select resets to zero so the pin shows live lock state.
// [RULE15] Frequencies are compared by counting edges over a fixed window.
`timescale 1ns/10ps
module cdr_lock_detector #(
    parameter int unsigned MEAS_WIN_CYC = cdr_lock_pkg::MEAS_WINDOW_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Front-end pins
    input wire logic osc_div_i,
    input wire logic data_div_i,
    input wire logic reference_clock_in_i,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Loop control and indication
    output logic loss_of_lock_out_o,
    output logic [cdr_lock_pkg::TUNE_W-1:0] vco_tune_o,
    output logic fll_enable_o,
    output logic dpll_enable_o,
    output logic irq_o
);
    import cdr_lock_pkg::*;

    // A short window cannot resolve 250 ppm; it only suits exactly matched
    // rates, so real use keeps the long default window
    localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(MEAS_WIN_CYC - 1);

    logic [2:0] pin_raw;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] pin_rise;
    logic [CNT_W-1:0] win_cnt;
    logic [CNT_W-1:0] osc_cnt;
    logic [CNT_W-1:0] dat_cnt;
    logic [CNT_W-1:0] ref_cnt;
    logic [WIDE_W-1:0] osc_meas;
    logic [WIDE_W-1:0] tgt_meas;
    logic meas_valid;
    logic settle;
    logic loss_of_lock_out;
    logic sticky;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    ctrl_a_type ctrl_a;
    ctrl_b_type ctrl_b;
    acq_state_type state;
    acq_state_type next_state;
    logic [TUNE_W-1:0] next_tune;
    logic next_settle;
    logic next_lol;
    logic next_sticky;
    logic [1:0] next_irq_st;

    // Two flops per pin, a third flop only for edge detection
    // Nothing but the second flop reads the first, so metastability stays put
    assign pin_raw = {reference_clock_in_i, data_div_i, osc_div_i};
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge clk_sys_i) begin
                sync1[g] <= sys_rst_i ? 1'b0 : pin_raw[g];
                sync2[g] <= sys_rst_i ? 1'b0 : sync1[g];
                sync3[g] <= sys_rst_i ? 1'b0 : sync2[g];
            end
            assign pin_rise[g] = sync2[g] & ~sync3[g];
        end
    endgenerate

    // Window timing and edge counts
    wire win_done = (win_cnt == WIN_LAST);
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || win_done) begin
            win_cnt <= '0;
        end else begin
            win_cnt <= win_cnt + 1'b1;
        end
    end

    // Edges on the closing cycle are dropped from all counts alike
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || win_done) begin
            osc_cnt <= '0; // RULE15
            dat_cnt <= '0;
            ref_cnt <= '0;
        end else begin
            osc_cnt <= osc_cnt + CNT_W'(pin_rise[0]);
            dat_cnt <= dat_cnt + CNT_W'(pin_rise[1]);
            ref_cnt <= ref_cnt + CNT_W'(pin_rise[2]);
        end
    end

    // Target count: data edges, or reference scaled by ratio and range
    // A stopped target counts zero, which always reads as out of lock
    wire [WIDE_W-1:0] ref_wide = WIDE_W'(ref_cnt);
    wire [WIDE_W-1:0] ref_scaled =
        (ref_wide << ctrl_a.rate_divide_ratio) >> ctrl_a.ref_freq_range; // RULE9
    wire [WIDE_W-1:0] tgt_sel =
        ctrl_a.ref_lock_select ? ref_scaled : WIDE_W'(dat_cnt); // RULE6 RULE7

    always_ff @(posedge clk_sys_i) begin
        meas_valid <= ~sys_rst_i & win_done;
        if (sys_rst_i) begin
            osc_meas <= '0;
            tgt_meas <= '0;
        end else if (win_done) begin
            osc_meas <= WIDE_W'(osc_cnt);
            tgt_meas <= tgt_sel;
        end
    end

    // Error against thresholds in ppm of the target
    // Products stay inside 48 bits for 24-bit counts and ratio codes up to 4
    wire osc_below = osc_meas < tgt_meas;
    wire [WIDE_W-1:0] err = osc_below ? tgt_meas - osc_meas : osc_meas - tgt_meas;
    wire [WIDE_W-1:0] err_ppm = WIDE_W'(err * PPM_SCALE);
    wire no_target = (tgt_meas == '0);
    wire over_upper = no_target || (err_ppm > WIDE_W'(tgt_meas * UPPER_PPM)); // RULE1
    wire within_lower = !no_target && (err_ppm <= WIDE_W'(tgt_meas * LOWER_PPM));

    // Step size falls as the oscillator nears the target
    wire big_err = WIDE_W'(err * BIG_FRAC) > tgt_meas;
    wire mid_err = WIDE_W'(err * MID_FRAC) > tgt_meas;
    wire [TUNE_W-1:0] step = big_err ? STEP_BIG : (mid_err ? STEP_MID : STEP_FINE); // RULE4
    wire [TUNE_W-1:0] room = TUNE_MAX - vco_tune_o;

    // Register access decode
    // Accesses complete only on the answer cycle; the wait cycle only captures read data
    wire bus_req = avs_read_i | avs_write_i;
    wire acc_fire = bus_req & ~avs_waitrequest_o;
    wire wr_fire = avs_write_i & ~avs_waitrequest_o;
    wire wr_ctrl_a = wr_fire && (avs_address_i == OFF_CTRL_A);
    wire wr_ctrl_b = wr_fire && (avs_address_i == OFF_CTRL_B);
    wire wr_mask = wr_fire && (avs_address_i == OFF_IRQ_MASK);
    wire rd_irq = avs_read_i && ~avs_waitrequest_o && (avs_address_i == OFF_IRQ_STATUS);
    wire ctrl_b_type wdata_b = ctrl_b_type'(avs_writedata_i[7:0]);
    wire ctrl_a_type next_ctrl_a = wr_ctrl_a ? ctrl_a_type'(avs_writedata_i[7:0]) : ctrl_a;
    wire ctrl_b_type next_ctrl_b = wr_ctrl_b ? wdata_b : ctrl_b;

    // Acquisition sequencing
    always_comb begin
        next_state = state;
        next_tune = vco_tune_o;
        next_settle = settle;
        next_lol = loss_of_lock_out;
        unique case (state)
            ST_RESTART: begin
                // Every new search starts from the bottom code, one window discarded
                next_tune = TUNE_MIN; // RULE2
                next_settle = 1'b1;
                next_lol = 1'b1;
                next_state = ST_SEARCH;
            end
            ST_SEARCH: begin
                if (meas_valid) begin
                    if (settle) begin
                        // First window after a step holds a mix of two tunings
                        next_settle = 1'b0;
                    end else if (within_lower) begin
                        next_lol = 1'b0; // RULE4 RULE9
                        next_state = ST_LOCKED; // RULE5
                    end else if (osc_below && (step <= room)) begin
                        next_tune = vco_tune_o + step; // RULE3
                        next_settle = 1'b1;
                    end else begin
                        // Overshoot or top of range: only an upward search exists
                        next_state = ST_RESTART;
                    end
                end
            end
            ST_LOCKED: begin
                // Frequency loop idle; the phase loops own the oscillator now
                if (meas_valid && over_upper) begin
                    next_lol = 1'b1; // RULE1 RULE10
                    next_state = ST_RESTART;
                end
            end
            // Unused state code falls back to a fresh search
            default: begin
                next_state = ST_RESTART;
            end
        endcase
        // New mode or target reacquires from scratch
        if (wr_ctrl_a && (next_ctrl_a != ctrl_a)) begin
            next_lol = 1'b1;
            next_state = ST_RESTART;
        end
    end

    // State and tune move together so the far side never sees a stale code
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state <= ST_RESTART;
            vco_tune_o <= TUNE_MIN;
            settle <= 1'b1;
            loss_of_lock_out <= 1'b1;
        end else begin
            state <= next_state;
            vco_tune_o <= next_tune;
            settle <= next_settle;
            loss_of_lock_out <= next_lol;
        end
    end

    // Events; a set always beats a clear in the same cycle
    // Reset starts with lol high, so it never counts as a loss event
    wire lol_rise = next_lol & ~loss_of_lock_out;
    wire lock_gain = ~next_lol & loss_of_lock_out;
    // Clear needs a stored one followed by a written zero
    wire sticky_clr = wr_ctrl_b && ctrl_b.sticky_clear_bit && !wdata_b.sticky_clear_bit; // RULE12
    assign next_sticky = lol_rise | (sticky & ~sticky_clr); // RULE11
    wire [1:0] irq_ev = {lock_gain, lol_rise};
    wire [1:0] irq_clr = rd_irq ? avs_readdata_o[1:0] : 2'h0;
    assign next_irq_st = irq_ev | (irq_st & ~irq_clr);

    // Control and status registers
    // Reserved control bits are kept as written and read back unchanged
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ctrl_a <= ctrl_a_type'(CTRL_A_RST);
            ctrl_b <= ctrl_b_type'(CTRL_B_RST); // RULE14
            irq_mask <= IRQ_MASK_RST;
            sticky <= 1'b0;
            irq_st <= 2'h0;
        end else begin
            ctrl_a <= next_ctrl_a;
            ctrl_b <= next_ctrl_b;
            irq_mask <= wr_mask ? avs_writedata_i[1:0] : irq_mask;
            sticky <= next_sticky;
            irq_st <= next_irq_st;
        end
    end

    // Registered outputs track next values so the pins agree with state, except irq_o, which masks with the current irq_mask
    // Pin and status word change on the same edge, never a cycle apart
    wire pin_lol = next_ctrl_b.pin_sticky_select ? next_sticky : next_lol; // RULE13
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            loss_of_lock_out_o <= 1'b1;
            fll_enable_o <= 1'b1;
            dpll_enable_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            loss_of_lock_out_o <= pin_lol;
            fll_enable_o <= (next_state != ST_LOCKED); // RULE5
            dpll_enable_o <= (next_state == ST_LOCKED);
            irq_o <= |(next_irq_st & irq_mask);
        end
    end

    // Read data mux; unmapped offsets read as zero
    // Live state, sticky flag and tune code share one read-only word
    // Offsets decode in full, so unaligned aliases also read as zero
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_LOL_BIT] = loss_of_lock_out;
        status_word[ST_STICKY_BIT] = sticky;
        status_word[ST_TUNE_LSB +: TUNE_W] = vco_tune_o;
    end
    wire [31:0] rd_mux =
        (avs_address_i == OFF_CTRL_A) ? {24'h000000, ctrl_a} :
        (avs_address_i == OFF_CTRL_B) ? {24'h000000, ctrl_b} :
        (avs_address_i == OFF_STATUS) ? status_word :
        (avs_address_i == OFF_IRQ_STATUS) ? {30'h0, irq_st} :
        (avs_address_i == OFF_IRQ_MASK) ? {30'h0, irq_mask} : 32'h0000_0000;

    // One wait cycle per access; read data captured on the request cycle
    // A request still high after its answer is not taken twice: waitrequest
    // rises first, and a new request must meet a high waitrequest
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
            if (bus_req && avs_waitrequest_o && !acc_fire) begin
                avs_readdata_o <= rd_mux;
            end
        end
    end
endmodule : cdr_lock_detector

// ### rtl/cdr_lock_pkg.sv
// Constants, types and register map for the CDR lock detector
package cdr_lock_pkg;
    // Clock and measurement timing
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned MEAS_WINDOW_US = 1000;
    localparam int unsigned MEAS_WINDOW_CYC = MEAS_WINDOW_US * (CLK_HZ / 1_000_000);
    // Lock thresholds in ppm
    localparam int unsigned UPPER_PPM = 1000;
    localparam int unsigned LOWER_PPM = 250;
    localparam int unsigned PPM_SCALE = 1_000_000;
    // Oscillator tuning: code zero is the bottom of range, 12.3 MHz
    localparam int unsigned TUNE_W = 10;
    localparam logic [9:0] TUNE_MIN = 10'h000;
    localparam logic [9:0] TUNE_MAX = 10'h3FF;
    localparam logic [9:0] STEP_BIG = 10'h040;
    localparam logic [9:0] STEP_MID = 10'h008;
    localparam logic [9:0] STEP_FINE = 10'h001;
    // Error fractions that pick the step size
    localparam int unsigned BIG_FRAC = 8;
    localparam int unsigned MID_FRAC = 64;
    // Counter widths
    localparam int unsigned CNT_W = 24;
    localparam int unsigned WIDE_W = 48;
    // Avalon register byte offsets
    localparam logic [4:0] OFF_CTRL_A = 5'h00;
    localparam logic [4:0] OFF_CTRL_B = 5'h04;
    localparam logic [4:0] OFF_STATUS = 5'h08;
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h0C;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h10;
    // Status word field positions
    localparam int unsigned ST_LOL_BIT = 3;
    localparam int unsigned ST_STICKY_BIT = 4;
    localparam int unsigned ST_TUNE_LSB = 16;
    // Interrupt bits
    localparam int unsigned IRQ_LOL_BIT = 0;
    localparam int unsigned IRQ_LOCK_BIT = 1;
    // Reset values
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;

    // Control A layout, bit 7 down to bit 0
    typedef struct packed {
        logic [1:0] ref_freq_range;
        logic [3:0] rate_divide_ratio;
        logic rsvd;
        logic ref_lock_select;
    } ctrl_a_type;

    // Control B layout, bit 7 down to bit 0
    typedef struct packed {
        logic pin_sticky_select;
        logic sticky_clear_bit;
        logic [5:0] rsvd;
    } ctrl_b_type;

    // Acquisition states
    typedef enum logic [1:0] {
        ST_RESTART,
        ST_SEARCH,
        ST_LOCKED
    } acq_state_type;
endpackage : cdr_lock_pkg

// ### bench/cdr_lock_detector_assertions.sv
// Port-level checks for the CDR lock detector
`timescale 1ns/10ps
module cdr_lock_assertions #(
    parameter int unsigned MEAS_WIN_CYC = 64
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Front end
    input wire logic osc_div_i,
    input wire logic data_div_i,
    input wire logic reference_clock_in_i,
    // Register bus
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Loop outputs
    input wire logic loss_of_lock_out_o,
    input wire logic [cdr_lock_pkg::TUNE_W-1:0] vco_tune_o,
    input wire logic fll_enable_o,
    input wire logic dpll_enable_o,
    input wire logic irq_o
);
    import cdr_lock_pkg::*;
    logic psel;
    logic psel_d;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // Shadow of the pin mode bit; pin meaning changes on the same edge as it
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            psel <= 1'b0;
        end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == OFF_CTRL_B) begin
            psel <= avs_writedata_i[7];
        end
        psel_d <= psel;
    end
    property p_wait_one;
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("bus answer not one cycle");
    property p_unmapped;
        avs_read_i && !avs_waitrequest_o && avs_address_i > OFF_IRQ_MASK |-> avs_readdata_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_loops;
        dpll_enable_o != fll_enable_o;
    endproperty
    a_loops: assert property (p_loops) else $error("loop enables overlap");
    property p_tune_frozen;
        dpll_enable_o ##1 dpll_enable_o |-> $stable(vco_tune_o);
    endproperty
    a_tune_frozen: assert property (p_tune_frozen) else $error("tune moved while locked");
    property p_restart_min;
        $rose(fll_enable_o) |-> ##[0:2] vco_tune_o == TUNE_MIN;
    endproperty
    a_restart_min: assert property (p_restart_min) else $error("no restart at bottom");
    property p_step_up;
        fll_enable_o && !$stable(vco_tune_o) && vco_tune_o != TUNE_MIN |->
            vco_tune_o == $past(vco_tune_o) + STEP_BIG || vco_tune_o == $past(vco_tune_o) + STEP_MID
            || vco_tune_o == $past(vco_tune_o) + STEP_FINE;
    endproperty
    a_step_up: assert property (p_step_up) else $error("bad search step");
    property p_live_pin;
        !psel && !psel_d |-> loss_of_lock_out_o == fll_enable_o;
    endproperty
    a_live_pin: assert property (p_live_pin) else $error("pin not live state");
    property p_sticky_pin;
        psel && psel_d && $rose(fll_enable_o) |-> ##[0:2] loss_of_lock_out_o;
    endproperty
    a_sticky_pin: assert property (p_sticky_pin) else $error("sticky pin missed loss");
    c_lock: cover property ($fell(fll_enable_o));
    c_irq: cover property ($rose(irq_o));
    c_sticky_view: cover property (psel && loss_of_lock_out_o && dpll_enable_o);
endmodule : cdr_lock_assertions

bind cdr_lock_detector cdr_lock_assertions #(.MEAS_WIN_CYC(MEAS_WIN_CYC)) u_chk (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .osc_div_i(osc_div_i),
    .data_div_i(data_div_i), .reference_clock_in_i(reference_clock_in_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .loss_of_lock_out_o(loss_of_lock_out_o),
    .vco_tune_o(vco_tune_o), .fll_enable_o(fll_enable_o), .dpll_enable_o(dpll_enable_o),
    .irq_o(irq_o));

// ### bench/cdr_front_end_model.sv
// Behavioural front end: divided oscillator, data and reference waves
`timescale 1ns/10ps
module cdr_front_end_model #(
    parameter logic [9:0] LOCK_TUNE = 10'h040
) (
    // Clock
    input wire logic clk_sys_i,
    // Control
    input wire logic [9:0] vco_tune_i,
    input wire logic data_en_i,
    input wire logic ref_en_i,
    // Divided waves
    output logic osc_div_o,
    output logic data_div_o,
    output logic ref_clk_o
);
    logic [3:0] phase = 4'h0;
    // One counter keeps all waves commensurate, so counts match exactly
    always @(posedge clk_sys_i) phase <= phase + 4'h1;
    // Data rate only at the lock code; half rate anywhere else
    assign osc_div_o = (vco_tune_i == LOCK_TUNE) ? phase[2] : phase[3];
    // A stopped stream or reference holds its line low
    assign data_div_o = data_en_i & phase[2];
    assign ref_clk_o = ref_en_i & phase[3];
endmodule : cdr_front_end_model

// ### bench/tb_cdr_lock_detector.sv
// Self-checking bench for the CDR lock detector
`timescale 1ns/10ps
module tb_cdr_lock_detector;
    import cdr_lock_pkg::*;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic osc_div_i, data_div_i, reference_clock_in_i;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o, rd;
    logic avs_waitrequest_o, loss_of_lock_out_o, fll_enable_o, dpll_enable_o, irq_o;
    logic [TUNE_W-1:0] vco_tune_o;
    logic data_en = 1'b1;
    logic ref_en = 1'b1;
    int failures = 0;
    int check_count = 0;
    // Short window keeps each lock attempt to a few hundred cycles
    cdr_lock_detector #(.MEAS_WIN_CYC(64)) DUT (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .osc_div_i(osc_div_i),
        .data_div_i(data_div_i), .reference_clock_in_i(reference_clock_in_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .loss_of_lock_out_o(loss_of_lock_out_o),
        .vco_tune_o(vco_tune_o), .fll_enable_o(fll_enable_o), .dpll_enable_o(dpll_enable_o),
        .irq_o(irq_o));
    cdr_front_end_model u_far (
        .clk_sys_i(clk_sys_i), .vco_tune_i(vco_tune_o), .data_en_i(data_en),
        .ref_en_i(ref_en), .osc_div_o(osc_div_i), .data_div_o(data_div_i),
        .ref_clk_o(reference_clock_in_i));
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Request held until waitrequest is sampled low; one idle edge after
    task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge clk_sys_i);
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : acc
    task automatic wait_pin(input logic lvl);
        int n;
        n = 0;
        while (loss_of_lock_out_o !== lvl && n < 3000) begin
            @(posedge clk_sys_i);
            n++;
        end
        repeat (2) @(posedge clk_sys_i);
        chk({31'h0, loss_of_lock_out_o}, {31'h0, lvl});
    endtask : wait_pin
    task automatic t_reset();
        chk({31'h0, loss_of_lock_out_o}, 32'h1);
        acc(1'b0, OFF_CTRL_B, 32'h0);
        chk(rd & 32'hFF, 32'h0);
        acc(1'b0, 5'h14, 32'h0);
        chk(rd, 32'h0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_normal();
        wait_pin(1'b0);
        chk({22'h0, vco_tune_o}, 32'h40);
        chk({30'h0, fll_enable_o, dpll_enable_o}, 32'h1);
        acc(1'b0, OFF_STATUS, 32'h0);
        chk(rd & 32'h03FF_0018, 32'h0040_0000);
        $display("t_normal done");
    endtask : t_normal
    task automatic t_loss();
        acc(1'b1, OFF_IRQ_MASK, 32'h1);
        acc(1'b0, OFF_IRQ_STATUS, 32'h0);
        data_en <= 1'b0;
        wait_pin(1'b1);
        chk({31'h0, irq_o}, 32'h1);
        acc(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        repeat (2) @(posedge clk_sys_i);
        chk({31'h0, irq_o}, 32'h0);
        data_en <= 1'b1;
        wait_pin(1'b0);
        acc(1'b0, OFF_STATUS, 32'h0);
        chk(rd & 32'h03FF_0018, 32'h0040_0010);
        $display("t_loss done");
    endtask : t_loss
    // Sticky pin view held across a loss and the relock after it
    task automatic t_sticky();
        int n;
        n = 0;
        acc(1'b1, OFF_CTRL_B, 32'h80);
        repeat (3) @(posedge clk_sys_i);
        chk({31'h0, loss_of_lock_out_o}, 32'h1);
        acc(1'b1, OFF_CTRL_B, 32'hC0);
        acc(1'b1, OFF_CTRL_B, 32'h80);
        repeat (3) @(posedge clk_sys_i);
        chk({31'h0, loss_of_lock_out_o}, 32'h0);
        data_en <= 1'b0;
        wait_pin(1'b1);
        data_en <= 1'b1;
        while (dpll_enable_o !== 1'b1 && n < 3000) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk({31'h0, dpll_enable_o}, 32'h1);
        chk({31'h0, loss_of_lock_out_o}, 32'h1);
        acc(1'b1, OFF_CTRL_B, 32'hC0);
        acc(1'b1, OFF_CTRL_B, 32'h80);
        repeat (3) @(posedge clk_sys_i);
        chk({31'h0, loss_of_lock_out_o}, 32'h0);
        acc(1'b1, OFF_CTRL_B, 32'h0);
        $display("t_sticky done");
    endtask : t_sticky
    // Data stays stopped, so only the reference can bring lock
    task automatic t_ref();
        acc(1'b1, OFF_IRQ_MASK, 32'h0);
        data_en <= 1'b0;
        acc(1'b1, OFF_CTRL_A, 32'h05);
        wait_pin(1'b0);
        chk({22'h0, vco_tune_o}, 32'h40);
        acc(1'b0, OFF_CTRL_A, 32'h0);
        chk(rd & 32'hFF, 32'h05);
        ref_en <= 1'b0;
        wait_pin(1'b1);
        chk({31'h0, irq_o}, 32'h0);
        ref_en <= 1'b1;
        wait_pin(1'b0);
        acc(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk(rd & 32'h3, 32'h3);
        acc(1'b1, OFF_CTRL_A, 32'h49);
        chk({31'h0, loss_of_lock_out_o}, 32'h1);
        wait_pin(1'b0);
        chk({22'h0, vco_tune_o}, 32'h40);
        $display("t_ref done");
    endtask : t_ref
    task automatic give_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    // Tests need a few thousand cycles; allow ten times that
    initial begin
        #(40 * 40000);
        failures++;
        $display("ERROR at %0t: watchdog expired", $time);
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_normal();
        t_loss();
        t_sticky();
        t_ref();
        give_verdict();
    end
endmodule : tb_cdr_lock_detector
